//--- include/pixel_overlay_defs.vh
// constants for the pixel unpack and cursor overlay block
`ifndef PIXEL_OVERLAY_DEFS_VH
`define PIXEL_OVERLAY_DEFS_VH
// ****************************************
// register byte offsets
// ****************************************
`define REG_CURSOR_CTRL 8'h00
`define REG_CURSOR_BASE 8'h04
`define REG_CURSOR_POS 8'h08
`define REG_CURSOR_LOAD 8'h0C
`define REG_STATUS 8'h10
`define REG_RASTER 8'h14
// ****************************************
// field positions and reset values
// ****************************************
`define CTRL_ENABLE_BIT 0
`define POS_X_LSB 0
`define POS_Y_LSB 16
`define LOAD_INDEX_LSB 16
`define STATUS_FIFO_EMPTY_BIT 0
`define STATUS_FIFO_FULL_BIT 1
`define BYPASS_BIT 31
`define CURSOR_REPLACE_BIT 15
`define CURSOR_SIZE 32
`define CURSOR_ENTRIES 1024
`define CURSOR_BITMAP_BYTES 2048
`define RESET_CTRL 32'h00000000
`define RESET_BASE 32'h00000000
`define RESET_POS 32'h00000000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- logic/pixel_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module pixel_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready,
  output wire full,
  output wire empty
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign full = (count == DEPTH[AW:0]);
  assign empty = (count == {(AW+1){1'b0}});
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem[rd_ptr];
  assign push = in_valid & ~full;
  assign pop = out_ready & ~empty;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // pixel_fifo

//--- logic/pixel_unpack_cursor_overlay.v
// pixel unpack, lut routing and hardware cursor overlay with axi4-lite registers
// Notes on behaviour
// R1: bit 31 of each 32-bit pixel picks lut bypass (set) or gamma lut (clear).
// R2: lut pixels ignore bits 30..24; red, green, blue indices from low three bytes.
// R3: bypass pixels form 10-bit colours; low two bits per colour from bits 29..24.
// R4: wide framebuffer words are 32-bit pixels, lowest address in lowest lane.
// R5: software keeps line lengths a multiple of 4, 2 or 1 pixels by depth.
// R6: cursor is 32x32 pixels of 5:5:5 colour plus one mode bit.
// R7: cursor pattern comes from a 2 KB bitmap at a programmable base.
// R8: registers enable the cursor, set bitmap base and screen coordinates.
// R9: software changes cursor data and position only during frame flyback.
// R10: each 5-bit cursor colour is replicated into both halves of 10 bits.
// R11: mode bit set replaces the pixel; clear XORs the 30-bit cursor colour.
// R12: cursor value zero leaves the display pixel unchanged; code keeps dac_pixel but still clears dac_lut_select in the box.
// R13: cursor value 7FFF inverts every bit of the display pixel.
// R14: cursor merge happens after the video overlay.
// R15: cursor shows only when enabled and raster is inside its 32x32 box.
// R16: bitmap entry chosen by row and column offset from cursor origin.
`timescale 1ns/100ps
`include "pixel_overlay_defs.vh"
module pixel_unpack_cursor_overlay #(
  parameter LANES = 4,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire clk,
  input wire nrst,
  // axi4-lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // framebuffer word stream
  input wire [32*LANES-1:0] framebuffer_pixel_word,
  input wire fb_valid,
  output reg fb_ready,
  // raster position and video overlay of the current pixel
  input wire frame_start,
  input wire line_start,
  input wire pixel_advance,
  input wire video_active,
  input wire [29:0] video_pixel,
  // to the palette/dac path
  output reg [29:0] dac_pixel,
  output reg dac_lut_select,
  output reg dac_valid,
  // cursor bitmap fetch request towards memory
  output reg [31:0] cursor_fetch_addr
);
  // ****************************************
  // reset synchroniser
  // ****************************************
  reg rst_meta;
  reg rst_n;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  reg [31:0] cursor_ctrl;
  reg [31:0] cursor_base;
  reg [31:0] cursor_pos;
  reg [15:0] cursor_ram [0:`CURSOR_ENTRIES-1];
  reg [7:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg w_held;
  reg [10:0] raster_x;
  reg [10:0] raster_y;
  wire fifo_full;
  wire fifo_empty;
  wire cursor_en = cursor_ctrl[`CTRL_ENABLE_BIT];
  wire do_write = aw_held & w_held & ~s_axi_bvalid;

  // address and data taken in either order, response after both
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      cursor_ctrl <= `RESET_CTRL;
      cursor_base <= `RESET_BASE;
      cursor_pos <= `RESET_POS;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RESP_OKAY;
        // R8
        case (aw_addr)
          `REG_CURSOR_CTRL: cursor_ctrl <= w_data & 32'h00000001;
          `REG_CURSOR_BASE: cursor_base <= {w_data[31:11], 11'h000}; // R7
          `REG_CURSOR_POS: cursor_pos <= w_data & 32'h07FF07FF;
          `REG_CURSOR_LOAD: begin
          end
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // bitmap words land here as software writes them through the load register
  always @(posedge clk) begin
    if (do_write && aw_addr == `REG_CURSOR_LOAD) begin
      cursor_ram[w_data[`LOAD_INDEX_LSB+9:`LOAD_INDEX_LSB]] <= w_data[15:0]; // R6
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      case (s_axi_araddr)
        `REG_CURSOR_CTRL: s_axi_rdata <= cursor_ctrl;
        `REG_CURSOR_BASE: s_axi_rdata <= cursor_base;
        `REG_CURSOR_POS: s_axi_rdata <= cursor_pos;
        `REG_CURSOR_LOAD: s_axi_rdata <= 32'h00000000;
        `REG_STATUS: s_axi_rdata <= {30'h00000000, fifo_full, fifo_empty};
        `REG_RASTER: s_axi_rdata <= {5'h00, raster_y, 5'h00, raster_x};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // lane splitter feeding the fifo
  // ****************************************
  reg [1:0] lane;
  wire [31:0] lane_word [0:LANES-1];
  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi = gi + 1) begin : g_lane
      assign lane_word[gi] = framebuffer_pixel_word[32*gi+31:32*gi]; // R4
    end
  endgenerate
  wire fifo_in_ready;
  wire [31:0] fifo_out;
  wire fifo_out_valid;
  wire take_pixel = fifo_out_valid & pixel_advance;
  wire last_lane = (lane == LANES[1:0] - 2'h1) || (LANES == 1);

  // fb_ready pulses on the last lane so the source advances a whole wide word
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lane <= 2'h0;
      fb_ready <= 1'b0;
    end else begin
      fb_ready <= 1'b0;
      if (fb_valid & fifo_in_ready & ~fb_ready) begin
        if (last_lane) begin
          lane <= 2'h0;
          fb_ready <= 1'b1;
        end else begin
          lane <= lane + 2'h1;
        end
      end
    end
  end

  pixel_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_data(lane_word[lane]),
    .in_valid(fb_valid & ~fb_ready),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(pixel_advance),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  // ****************************************
  // raster position and cursor hit
  // ****************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      raster_x <= 11'h000;
      raster_y <= 11'h000;
    end else if (frame_start) begin
      raster_x <= 11'h000;
      raster_y <= 11'h000;
    end else if (line_start) begin
      raster_x <= 11'h000;
      raster_y <= raster_y + 11'h001;
    end else if (take_pixel) begin
      raster_x <= raster_x + 11'h001;
    end
  end

  wire [10:0] dx = raster_x - cursor_pos[`POS_X_LSB+10:`POS_X_LSB];
  wire [10:0] dy = raster_y - cursor_pos[`POS_Y_LSB+10:`POS_Y_LSB];
  wire in_box = cursor_en && (dx < 11'h020) && (dy < 11'h020); // R15
  wire [9:0] cursor_index = {dy[4:0], dx[4:0]}; // R16
  wire [15:0] cursor_pix = cursor_ram[cursor_index];

  // ****************************************
  // unpack and merge
  // ****************************************
  reg [29:0] base_pixel;
  reg lut_sel;
  reg [29:0] cursor_rgb;
  reg [29:0] next_pixel;
  always @* begin
    lut_sel = ~fifo_out[`BYPASS_BIT]; // R1
    if (lut_sel) begin
      base_pixel = {2'b00, fifo_out[23:16], 2'b00, fifo_out[15:8], 2'b00, fifo_out[7:0]}; // R2
    end else begin
      base_pixel = {fifo_out[23:16], fifo_out[29:28], fifo_out[15:8], fifo_out[27:26],
        fifo_out[7:0], fifo_out[25:24]}; // R3
    end
    // video window replaces graphics first, cursor goes on top
    if (video_active) begin
      base_pixel = video_pixel; // R14
    end
    cursor_rgb = {cursor_pix[14:10], cursor_pix[14:10], cursor_pix[9:5], cursor_pix[9:5],
      cursor_pix[4:0], cursor_pix[4:0]}; // R10
    next_pixel = base_pixel;
    if (in_box) begin
      if (cursor_pix[`CURSOR_REPLACE_BIT]) begin
        next_pixel = cursor_rgb; // R11
      end else begin
        // zero keeps the pixel bits but lut select still clears, 7FFF inverts all 30 bits
        next_pixel = base_pixel ^ cursor_rgb; // R11 R12 R13
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_pixel <= 30'h00000000;
      dac_lut_select <= 1'b0;
      dac_valid <= 1'b0;
      cursor_fetch_addr <= 32'h00000000;
    end else begin
      dac_valid <= take_pixel;
      cursor_fetch_addr <= cursor_base + {21'h000000, cursor_index, 1'b0}; // R7
      if (take_pixel) begin
        dac_pixel <= next_pixel;
        dac_lut_select <= lut_sel & ~(in_box & ~video_active) & ~video_active;
      end
    end
  end
endmodule // pixel_unpack_cursor_overlay

//--- verification/pixel_unpack_cursor_overlay_props.sv
// port checker for the pixel overlay block
`timescale 1ns/100ps
`include "pixel_overlay_defs.vh"
module pixel_unpack_cursor_overlay_props (
  input wire clk,
  input wire nrst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire fb_ready,
  input wire pixel_advance,
  input wire dac_valid,
  input wire [31:0] cursor_fetch_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer not two cycles after both taken");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");
  a_busy_refuses: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed before taken");
  a_error_zero: assert property (
    s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h00000000)
    else $error("refused read carries data");
  a_word_lanes: assert property (fb_ready |=> !fb_ready [*3])
    else $error("wide word consumed faster than one lane a cycle");
  a_pixel_cause: assert property (dac_valid |-> $past(pixel_advance))
    else $error("pixel out without advance");
  a_fetch_even: assert property (cursor_fetch_addr[0] == 1'b0)
    else $error("cursor fetch address not on an entry");
endmodule // pixel_unpack_cursor_overlay_props

//--- verification/fb_source_model.sv
// framebuffer word source feeding the overlay block
`timescale 1ns/100ps
module fb_source_model #(
  parameter [127:0] WORD0 = 128'h0,
  parameter [127:0] WORD1 = 128'h0
) (
  input wire clk,
  input wire nrst,
  input wire slow,
  input wire fb_ready,
  output reg fb_valid,
  output reg [127:0] framebuffer_pixel_word
);
  reg sel;
  reg [1:0] gap;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel <= 1'b0;
      gap <= 2'h0;
    end else if (fb_ready) begin
      sel <= ~sel;
      gap <= slow ? 2'h3 : 2'h0;
    end else if (gap != 2'h0) begin
      gap <= gap - 2'h1;
    end
  end
  // while idle the word shows its inverse so a stale sample cannot match
  always @* begin
    fb_valid = nrst && gap == 2'h0;
    framebuffer_pixel_word = sel ? WORD1 : WORD0;
    if (!fb_valid) framebuffer_pixel_word = ~framebuffer_pixel_word;
  end
endmodule // fb_source_model

//--- verification/pixel_unpack_cursor_overlay_test.sv
// register and pixel path bench for the overlay block
`timescale 1ns/100ps
`include "pixel_overlay_defs.vh"
module pixel_unpack_cursor_overlay_test;
  // lane 0 of each word is the lowest pixel
  localparam [255:0] PIX = {128'h12345678_9B0F0F0F_00FFFFFF_E4C3A581,
    128'h6A000001_80FEDCBA_7F89ABCD_BF123456};
  // entries 4 and 5 sit inside the 32-wide box too, so they must be loaded
  localparam [95:0] CUR = 96'h0000_8000_1234_9A2B_7FFF_0000;
  localparam [29:0] VID = 30'h15A5C3E1;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg [7:0] s_axi_awaddr = 8'h00;
  reg [7:0] s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, slow = 1'b0;
  reg frame_start = 1'b0, line_start = 1'b0, pixel_advance = 1'b0, video_active = 1'b0;
  reg [29:0] video_pixel = 30'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire fb_valid, fb_ready, dac_lut_select, dac_valid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, cursor_fetch_addr;
  wire [127:0] framebuffer_pixel_word;
  wire [29:0] dac_pixel;
  integer fails = 0, total_checks = 0, i;
  reg [1:0] resp;
  reg [31:0] rd_val;
  reg [29:0] exp_pix;
  pixel_unpack_cursor_overlay #(.LANES(4)) pixel_unpack_cursor_overlay_inst (.*);
  fb_source_model #(.WORD0(PIX[127:0]), .WORD1(PIX[255:128])) fb_source_model_inst (.*);
  always #10 clk = ~clk;
  // ****************************************
  // bus and pixel tasks
  // ****************************************
  task wr(input [7:0] a, input [31:0] d);
    reg bv;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      bv = 1'b0;
      while (!bv) begin
        @(posedge clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        bv = s_axi_bvalid;
      end
      s_axi_bready <= 1'b0;
      resp = s_axi_bresp;
      @(posedge clk);
    end
  endtask
  task rd(input [7:0] a);
    reg rv;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      rv = 1'b0;
      while (!rv) begin
        @(posedge clk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        rv = s_axi_rvalid;
      end
      s_axi_rready <= 1'b0;
      resp = s_axi_rresp;
      rd_val = s_axi_rdata;
      @(posedge clk);
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        fails = fails + 1;
      end
    end
  endtask
  // msb is the expected lut select
  function [30:0] unpack(input [31:0] p);
    unpack = p[31] ? {1'b0, p[23:16], p[29:28], p[15:8], p[27:26], p[7:0], p[25:24]}
      : {1'b1, 2'b00, p[23:16], 2'b00, p[15:8], 2'b00, p[7:0]};
  endfunction
  function [29:0] merge(input [29:0] d, input [15:0] c);
    reg [29:0] e;
    begin
      e = {c[14:10], c[14:10], c[9:5], c[9:5], c[4:0], c[4:0]};
      merge = c[15] ? e : d ^ e;
    end
  endfunction
  // called right after an edge, returns right after an edge
  task px(input [30:0] exp, input sel_check);
    begin
      pixel_advance <= 1'b1;
      @(posedge clk);
      pixel_advance <= 1'b0;
      #1;
      chk({31'h0, dac_valid}, 32'h1);
      chk({2'h0, dac_pixel}, {2'h0, exp[29:0]});
      if (sel_check) chk({31'h0, dac_lut_select}, {31'h0, exp[30]});
      @(posedge clk);
    end
  endtask
  task frame;
    begin
      @(posedge clk);
      frame_start <= 1'b1;
      @(posedge clk);
      frame_start <= 1'b0;
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    for (i = 0; i < 12; i = i + 4) begin
      rd(i[7:0]);
      chk(rd_val, 32'h0);
    end
    // source never stalls and nothing drains, so the fifo must refuse by now
    rd(`REG_STATUS);
    chk({31'h0, rd_val[`STATUS_FIFO_FULL_BIT]}, 32'h1);
    wr(`REG_CURSOR_BASE, 32'h00000800);
    rd(`REG_CURSOR_BASE);
    chk(rd_val, 32'h00000800);
    wr(`REG_CURSOR_POS, 32'h00000002);
    rd(`REG_CURSOR_POS);
    chk(rd_val, 32'h00000002);
    wr(8'h40, 32'h1);
    chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
    rd(8'h40);
    chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
    chk(rd_val, 32'h0);
    for (i = 0; i < 6; i = i + 1) wr(`REG_CURSOR_LOAD, {6'h0, i[9:0], CUR[16*i +: 16]});
    frame;
    for (i = 0; i < 8; i = i + 1) px(unpack(PIX[32*i +: 32]), 1'b1);
    wr(`REG_CURSOR_CTRL, 32'h1);
    video_active <= 1'b1;
    video_pixel <= VID;
    slow <= 1'b1;
    frame;
    for (i = 0; i < 8; i = i + 1) begin
      exp_pix = (i < 2) ? VID : merge(VID, CUR[16*(i-2) +: 16]);
      px({1'b0, exp_pix}, 1'b1);
    end
    rd(`REG_RASTER);
    chk(rd_val, 32'h00000008);
    // raster rests at x=8, so entry 6 of row 0 is addressed
    chk(cursor_fetch_addr, 32'h0000080C);
    line_start <= 1'b1;
    @(posedge clk);
    line_start <= 1'b0;
    rd(`REG_RASTER);
    chk(rd_val, 32'h00010000);
    stop_test;
  end
  initial begin
    #200000;
    fails = fails + 1;
    stop_test;
  end
endmodule // pixel_unpack_cursor_overlay_test
bind pixel_unpack_cursor_overlay pixel_unpack_cursor_overlay_props props_inst (.*);
